// ===== src/mrb_params.svh
`ifndef MRB_PARAMS_SVH
`define MRB_PARAMS_SVH

// Clock period
`define MRB_CLK_PERIOD_NS 10

// Time the reset line is held low after power-on reset ends
`define MRB_POR_HOLD_NS 1000

// Hold time in cycles, rounded up, at least one
`define MRB_POR_HOLD_CYC \
   (((`MRB_POR_HOLD_NS + `MRB_CLK_PERIOD_NS - 1) / `MRB_CLK_PERIOD_NS) < 1 ? \
    1 : ((`MRB_POR_HOLD_NS + `MRB_CLK_PERIOD_NS - 1) / `MRB_CLK_PERIOD_NS))

// Hold counter width
`define MRB_CNT_W 16

// Field positions in the synchroniser vector
`define MRB_SYN_EXTRST 0
`define MRB_SYN_DLSTRAP 1
`define MRB_SYN_DBGA 2
`define MRB_SYN_DBGB 3
`define MRB_SYN_CTS 4
`define MRB_SYN_W 5

// Idle level of the synchronised pins: all pulled high except the straps
`define MRB_SYN_RESET 5'h11

// Reset values of the captured straps
`define MRB_DL_RESET 1'h0
`define MRB_DBG_RESET 2'h0

`endif

// ===== src/mrb_pkg.sv
package mrb_pkg;

   typedef enum logic [3:0] {
      MRB_POR = 4'h1,
      MRB_HOLD = 4'h2,
      MRB_RUN = 4'h4,
      MRB_EXTRST = 4'h8
   } mrb_phase_type;

   typedef struct packed {
      logic downloadWait;
      logic [1:0] debugCfg;
   } mrb_straps_type;

   typedef struct packed {
      logic resetOe;
      logic flowOe;
      logic flowOut;
      logic [1:0] debugOe;
      logic [1:0] debugOut;
   } mrb_pins_type;

   typedef struct packed {
      mrb_phase_type phase;
      logic [15:0] count;
      mrb_straps_type straps;
      mrb_pins_type pins;
      logic moduleReset;
      logic memInit;
      logic bootNormal;
   } mrb_state_type;

endpackage

// ===== src/mrb_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none

module mrb_pin_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Asynchronous pins in, stable values out
   input wire logic [W-1:0] pinIn,
   output logic [W-1:0] pinOut
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] stable;
   } mrb_sync_type;

   mrb_sync_type st_reg;
   mrb_sync_type st_next;

   always_comb begin
      st_next = st_reg;
      st_next.s1 = pinIn;
      st_next.s2 = st_reg.s1;
      st_next.s3 = st_reg.s2;
      // Only the later two stages are compared; s1 may be metastable
      for (int i = 0; i < W; i++) begin
         if (st_reg.s2[i] == st_reg.s3[i]) begin
            st_next.stable[i] = st_reg.s3[i];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_reg <= {INIT, INIT, INIT, INIT};
      end else begin
         st_reg <= st_next;
      end
   end

   assign pinOut = st_reg.stable;

endmodule

`default_nettype wire

// ===== src/mrb_reset_straps.sv
`include "mrb_params.svh"
`timescale 1ns/1ps
`default_nettype none

module mrb_reset_straps #(
   parameter int unsigned HOLD_CYC = `MRB_POR_HOLD_CYC
) (
   // Clock and internal power-on reset
   input wire logic clk,
   input wire logic rst,
   // Shared open-drain reset line, active low
   input wire logic extResetNIn,
   output logic extResetNOut,
   output logic extResetNOe,
   // Internal pull-down requests on the reset line
   input wire logic rtcResetReq,
   input wire logic vmonResetReq,
   // Download strap pin, second serial flow output afterwards
   input wire logic downloadStrapPinIn,
   output logic downloadStrapPinOut,
   output logic downloadStrapPinOe,
   // Debug configuration strap pins, a in bit 0, b in bit 1
   input wire logic [1:0] debugCfgStrapIn,
   output logic [1:0] debugCfgStrapOut,
   output logic [1:0] debugCfgStrapOe,
   // Serial flow control, pin side
   input wire logic clearToSendNIn,
   // Core side
   input wire logic debugPortEn,
   input wire logic [1:0] debugPinValue,
   input wire logic serialRxReady,
   output logic serialTxAllowed,
   output logic moduleReset,
   output logic memInit,
   output logic bootNormal,
   output mrb_pkg::mrb_straps_type straps
);
   import mrb_pkg::*;

   localparam logic [15:0] HOLD_LAST = 16'(HOLD_CYC - 1);

   mrb_state_type st_reg;
   mrb_state_type st_next;
   logic [`MRB_SYN_W-1:0] pinsRaw;
   logic [`MRB_SYN_W-1:0] pinsSync;
   logic lineLow;
   logic capture;
   // Hold period counted out; our own low is being let go
   logic holdDone;
   // We still drive the line for power-on
   logic porDrive;
   // Either on-module source wants the line low
   logic internalPull;

   assign pinsRaw = {clearToSendNIn, debugCfgStrapIn[1], debugCfgStrapIn[0],
                     downloadStrapPinIn, extResetNIn};

   mrb_pin_sync #(
      .W(`MRB_SYN_W),
      .INIT(`MRB_SYN_RESET)
   ) u_sync (
      .clk(clk),
      .rst(rst),
      .pinIn(pinsRaw),
      .pinOut(pinsSync)
   );

   // Wired-AND: anyone pulling low wins, including our own drivers
   assign lineLow = ~pinsSync[`MRB_SYN_EXTRST];

   always_comb begin
      st_next = st_reg;
      capture = 1'b0;
      holdDone = 1'b0;
      porDrive = 1'b0;
      internalPull = 1'b0;
      case (st_reg.phase)
         MRB_POR: begin
            // Reset has just released; start the hold period
            st_next.phase = MRB_HOLD;
            st_next.count = '0;
         end
         MRB_HOLD: begin
            if (st_reg.count != HOLD_LAST) begin
               st_next.count = st_reg.count + 16'h0001;
            end else if (!lineLow) begin
               // Our own low must leave the synchroniser first,
               // else RUN would see it and reset the module again
               st_next.phase = MRB_RUN;
               capture = 1'b1;
            end
         end
         MRB_RUN: begin
            if (lineLow) begin
               st_next.phase = MRB_EXTRST;
            end
         end
         MRB_EXTRST: begin
            if (!lineLow) begin
               st_next.phase = MRB_RUN;
               capture = 1'b1;
            end
         end
         default: begin
            st_next.phase = MRB_POR;
            st_next.count = '0;
         end
      endcase

      // Straps are frozen except on the release cycle
      if (capture) begin
         st_next.straps.downloadWait = pinsSync[`MRB_SYN_DLSTRAP];
         st_next.straps.debugCfg[0] = pinsSync[`MRB_SYN_DBGA];
         st_next.straps.debugCfg[1] = pinsSync[`MRB_SYN_DBGB];
      end

      st_next.moduleReset = (st_next.phase != MRB_RUN);
      // Memory init only on power-on, never on the external line
      st_next.memInit = (st_next.phase == MRB_POR) ||
                        (st_next.phase == MRB_HOLD);
      st_next.bootNormal = (st_next.phase == MRB_RUN) &&
                           !st_next.straps.downloadWait;

      // Power-on drive plus RTC and monitor pull-downs
      // Drive is let go once the count is done; the phase then waits
      // for the line to read back high, so a host still pulling low
      // simply stretches the power-on phase
      holdDone = (st_next.count == HOLD_LAST);
      porDrive = (st_next.phase == MRB_POR) ||
                 ((st_next.phase == MRB_HOLD) && !holdDone);
      internalPull = rtcResetReq || vmonResetReq;
      st_next.pins.resetOe = porDrive || internalPull;

      // Strap pin stays an input until straps are taken
      st_next.pins.flowOe = (st_next.phase == MRB_RUN);
      // Low means ready to receive
      st_next.pins.flowOut = ~serialRxReady;

      // Debug pins are left floating for the strap sample
      if ((st_next.phase == MRB_RUN) && debugPortEn) begin
         st_next.pins.debugOe = 2'h3;
      end else begin
         st_next.pins.debugOe = 2'h0;
      end
      st_next.pins.debugOut = debugPinValue;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_reg.phase <= MRB_POR;
         st_reg.count <= '0;
         st_reg.straps.downloadWait <= `MRB_DL_RESET;
         st_reg.straps.debugCfg <= `MRB_DBG_RESET;
         st_reg.pins.resetOe <= 1'b1;
         st_reg.pins.flowOe <= 1'b0;
         st_reg.pins.flowOut <= 1'b1;
         st_reg.pins.debugOe <= 2'h0;
         st_reg.pins.debugOut <= 2'h0;
         st_reg.moduleReset <= 1'b1;
         st_reg.memInit <= 1'b1;
         st_reg.bootNormal <= 1'b0;
      end else begin
         st_reg <= st_next;
      end
   end

   // Open drain: only ever drives low
   assign extResetNOut = 1'b0;
   assign extResetNOe = st_reg.pins.resetOe;
   assign downloadStrapPinOut = st_reg.pins.flowOut;
   assign downloadStrapPinOe = st_reg.pins.flowOe;
   assign debugCfgStrapOut = st_reg.pins.debugOut;
   assign debugCfgStrapOe = st_reg.pins.debugOe;
   // Peer's clear-to-send is active low
   assign serialTxAllowed = ~pinsSync[`MRB_SYN_CTS];
   assign moduleReset = st_reg.moduleReset;
   assign memInit = st_reg.memInit;
   assign bootNormal = st_reg.bootNormal;
   assign straps = st_reg.straps;

endmodule

`default_nettype wire

// ===== bench/mrb_reset_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module mrb_reset_assertions #(
   parameter int unsigned HOLD_CYC = 4
) (
   // Clock, reset and reset line
   input wire logic clk, rst, extResetNIn, extResetNOut, extResetNOe,
   // Requests, flow and debug
   input wire logic rtcResetReq, vmonResetReq, clearToSendNIn,
   input wire logic serialRxReady, serialTxAllowed,
   input wire logic downloadStrapPinOut, downloadStrapPinOe, debugPortEn,
   input wire logic [1:0] debugPinValue, debugCfgStrapOut, debugCfgStrapOe,
   // Status
   input wire logic moduleReset, memInit, bootNormal,
   input wire mrb_pkg::mrb_straps_type straps
);
   import mrb_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_lineLow; !extResetNIn [*6]; endsequence
   sequence s_porHold; (extResetNOe && moduleReset) [*4]; endsequence
   property p_por; $fell(rst) |-> s_porHold; endproperty
   a_por: assert property (p_por) else $error("por hold");
   property p_drain; !extResetNOut; endproperty
   a_drain: assert property (p_drain) else $error("drive high");
   property p_pull; rtcResetReq || vmonResetReq |=> extResetNOe; endproperty
   a_pull: assert property (p_pull) else $error("pull");
   property p_ext; s_lineLow |-> moduleReset; endproperty
   a_ext: assert property (p_ext) else $error("ext reset");
   property p_keep; $rose(moduleReset) |-> !memInit; endproperty
   a_keep: assert property (p_keep) else $error("mem cleared");
   property p_boot; bootNormal |-> !straps.downloadWait; endproperty
   a_boot: assert property (p_boot) else $error("boot");
   property p_hold; !moduleReset && !$past(moduleReset) |-> $stable(straps);
   endproperty
   a_hold: assert property (p_hold) else $error("straps moved");
   property p_dbg; debugCfgStrapOe != 2'h0 |-> $past(debugPortEn) &&
      debugCfgStrapOe == 2'h3 && debugCfgStrapOut == $past(debugPinValue);
   endproperty
   a_dbg: assert property (p_dbg) else $error("debug pins");
   property p_rts;
      downloadStrapPinOe |-> downloadStrapPinOut == !$past(serialRxReady);
   endproperty
   a_rts: assert property (p_rts) else $error("rts");
   property p_cts;
      $stable(clearToSendNIn) [*6] |-> serialTxAllowed == !clearToSendNIn;
   endproperty
   a_cts: assert property (p_cts) else $error("cts");
endmodule
`default_nettype wire

// ===== bench/mrb_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module mrb_host_model (
   // Host and board controls
   input wire logic hostPull, hostReady, dlLevel,
   input wire logic [1:0] dbgLevel,
   // Device pins
   input wire logic extResetNOe, downloadStrapPinOut, downloadStrapPinOe,
   input wire logic [1:0] debugCfgStrapOut, debugCfgStrapOe,
   output logic extResetNIn, downloadStrapPinIn, clearToSendNIn,
   output logic [1:0] debugCfgStrapIn
);
   // Pulled up; host only ever pulls low
   assign extResetNIn = !(hostPull || extResetNOe);
   assign downloadStrapPinIn = downloadStrapPinOe ? downloadStrapPinOut :
      dlLevel;
   // Board resistors unless the device drives them; host leaves these alone
   assign debugCfgStrapIn = (debugCfgStrapOe & debugCfgStrapOut) |
      (~debugCfgStrapOe & dbgLevel);
   assign clearToSendNIn = !hostReady;
endmodule
`default_nettype wire

// ===== bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import mrb_pkg::*;
   localparam int unsigned HOLD = 4;
   logic clk, rst, hostPull, hostReady, dlLevel, rtcResetReq, vmonResetReq;
   logic debugPortEn, serialRxReady, extResetNIn, extResetNOut, extResetNOe;
   logic downloadStrapPinIn, downloadStrapPinOut, downloadStrapPinOe;
   logic clearToSendNIn, serialTxAllowed, moduleReset, memInit, bootNormal;
   logic [1:0] dbgLevel, debugPinValue, debugCfgStrapIn, debugCfgStrapOut;
   logic [1:0] debugCfgStrapOe;
   mrb_straps_type straps;
   int fails = 0;
   int nCompared = 0;
   mrb_reset_straps #(.HOLD_CYC(HOLD)) uut (.clk, .rst, .extResetNIn,
      .extResetNOut, .extResetNOe, .rtcResetReq, .vmonResetReq,
      .downloadStrapPinIn, .downloadStrapPinOut, .downloadStrapPinOe,
      .debugCfgStrapIn, .debugCfgStrapOut, .debugCfgStrapOe, .clearToSendNIn,
      .debugPortEn, .debugPinValue, .serialRxReady, .serialTxAllowed,
      .moduleReset, .memInit, .bootNormal, .straps);
   mrb_host_model host (.hostPull, .hostReady, .dlLevel, .dbgLevel,
      .extResetNOe, .downloadStrapPinOut, .downloadStrapPinOe,
      .debugCfgStrapOut, .debugCfgStrapOe, .extResetNIn,
      .downloadStrapPinIn, .clearToSendNIn, .debugCfgStrapIn);
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic check(string what, logic [3:0] exp, logic [3:0] got);
      nCompared++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic waitRun(output int n);
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (moduleReset !== 1'b0 && n < 40);
   endtask
   task automatic porBoot(logic dl, logic [1:0] dbg);
      int n;
      dlLevel = dl;
      dbgLevel = dbg;
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      check("hold", 4'h7, {1'b0, extResetNOe, moduleReset, memInit});
      waitRun(n);
      // Hold count plus the line's trip back through the synchroniser
      check("holdLen", 4'(HOLD + 4), 4'(n));
      check("run", 4'h0, {extResetNOe, memInit});
      check("straps", {1'b0, dl, dbg}, straps);
      check("boot", !dl, bootNormal);
   endtask
   task automatic extReset(logic dl, logic [1:0] dbg);
      int n;
      hostPull = 1'b1;
      dlLevel = dl;
      dbgLevel = dbg;
      repeat (6) @(negedge clk);
      check("ext", 4'h2, {downloadStrapPinOe, bootNormal, moduleReset,
         memInit});
      hostPull = 1'b0;
      waitRun(n);
      check("extLen", 4'h1, n < 8);
      check("straps2", {1'b0, dl, dbg}, straps);
   endtask
   task automatic internalPull();
      int n;
      for (int i = 0; i < 2; i++) begin
         {vmonResetReq, rtcResetReq} = 2'h1 << i;
         @(negedge clk);
         check("pull", 4'h1, extResetNOe);
         repeat (6) @(negedge clk);
         check("pullRst", 4'h1, moduleReset);
         {vmonResetReq, rtcResetReq} = 2'h0;
         waitRun(n);
         check("pullEnd", 4'h1, n < 12);
      end
   endtask
   task automatic flowCtl();
      for (int i = 0; i < 2; i++) begin
         serialRxReady = i[0];
         hostReady = i[0];
         repeat (5) @(negedge clk);
         check("rts", !i[0], downloadStrapPinOut);
         check("cts", i[0], serialTxAllowed);
      end
   endtask
   task automatic debugDrive();
      debugPortEn = 1'b1;
      debugPinValue = 2'h2;
      @(negedge clk);
      check("dbg", 4'hE, {debugCfgStrapOe, debugCfgStrapOut});
      check("dbgPin", 4'h2, debugCfgStrapIn);
      debugPortEn = 1'b0;
      @(negedge clk);
      check("dbgOff", 4'h0, debugCfgStrapOe);
   endtask
   task automatic tallyAndFinish();
      $display("compared %0d mismatches %0d", nCompared, fails);
      if (fails == 0 && nCompared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      {rst, hostPull, hostReady, dlLevel, rtcResetReq, vmonResetReq} = 6'h20;
      {debugPortEn, serialRxReady, dbgLevel, debugPinValue} = 6'h00;
      for (int i = 0; i < 4; i++) porBoot(i[0], 2'(i));
      flowCtl();
      debugDrive();
      internalPull();
      for (int i = 0; i < 4; i++) extReset(i[1], 2'(3 - i));
      tallyAndFinish();
   end
   initial begin
      #20000;
      fails++;
      tallyAndFinish();
   end
endmodule
bind mrb_reset_straps mrb_reset_assertions #(.HOLD_CYC(HOLD_CYC)) chk (
   .clk, .rst, .extResetNIn, .extResetNOut, .extResetNOe, .rtcResetReq,
   .vmonResetReq, .clearToSendNIn, .serialRxReady, .serialTxAllowed,
   .downloadStrapPinOut, .downloadStrapPinOe, .debugPortEn, .debugPinValue,
   .debugCfgStrapOut, .debugCfgStrapOe, .moduleReset, .memInit, .bootNormal,
   .straps);
`default_nettype wire
